// >>> bench/chg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module chg_host_model (
  input  wire logic              clk_i,
  input  wire logic [7:0]        rdata_i,
  output var  chg_pkg::chg_req_s  req_o
);
  import chg_pkg::*;
  initial req_o = '0;
  // One strobe cycle per access; read data is taken a cycle later.
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
    @(posedge clk_i);
    #1 q = rdata_i;
  endtask : xfer
endmodule : chg_host_model

`default_nettype wire

// >>> bench/chg_safety_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module chg_safety_ctrl_properties #(
  parameter int unsigned ALERT_CYC  = 8,
  parameter int unsigned DETECT_CYC = 8
) (
  input wire logic               ref_clk_i,
  input wire logic               resetn_i,
  input wire chg_pkg::chg_req_s   req_i,
  input wire chg_pkg::chg_sense_s sense_i,
  input wire logic               ceiling_clear_pin_n_i,
  input wire logic               charge_inhibit_pin_i,
  input wire logic [7:0]         rdata_o,
  input wire logic               alert_n_o,
  input wire logic               charge_en_bus_o,
  input wire logic               charge_en_aux_o,
  input wire logic               discharge_load_o,
  input wire logic               config_mode_o
);
  import chg_pkg::*;
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] low_n;
  logic [31:0] load_n;
  logic        any_en;
  assign any_en = charge_en_bus_o | charge_en_aux_o;
  ////////////////////////////////////////////////////////////
  // Width counters; a restarted alert only makes the pulse longer.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || alert_n_o) low_n <= '0;
    else low_n <= low_n + 32'h1;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !discharge_load_o) load_n <= '0;
    else load_n <= load_n + 32'h1;
  end
  ////////////////////////////////////////////////////////////
  a_inhibit_off : assert property (
    charge_inhibit_pin_i |=> !any_en) else $error("charge while inhibited");
  a_hot_off : assert property (
    sense_i.die_hot |=> !any_en) else $error("charge while hot");
  a_bus_ovp_off : assert property (
    sense_i.bus_ovp |=> !charge_en_bus_o) else $error("bus charge in ovp");
  a_aux_ovp_off : assert property (
    sense_i.aux_ovp |=> !charge_en_aux_o) else $error("aux charge in ovp");
  a_uv_stop : assert property (
    sense_i.input_low && any_en |-> ##2 !any_en)
    else $error("charge kept on low input");
  a_alert_delay : assert property (
    $rose(sense_i.bus_ovp) |-> ##2 !alert_n_o) else $error("alert late");
  a_alert_width : assert property (
    $rose(alert_n_o) |-> low_n >= ALERT_CYC) else $error("alert short");
  a_detect_width : assert property (
    $fell(discharge_load_o) |-> load_n >= DETECT_CYC)
    else $error("discharge short");
  a_read_hold : assert property (
    !$past(req_i.rd) |-> $stable(rdata_o)) else $error("read data moved");
endmodule : chg_safety_ctrl_properties

bind chg_safety_ctrl chg_safety_ctrl_properties #(
  .ALERT_CYC(ALERT_CYC), .DETECT_CYC(DETECT_CYC)) u_props (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req_i),
  .sense_i(sense_i), .ceiling_clear_pin_n_i(ceiling_clear_pin_n_i),
  .charge_inhibit_pin_i(charge_inhibit_pin_i), .rdata_o(rdata_o),
  .alert_n_o(alert_n_o), .charge_en_bus_o(charge_en_bus_o),
  .charge_en_aux_o(charge_en_aux_o),
  .discharge_load_o(discharge_load_o), .config_mode_o(config_mode_o));

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import chg_pkg::*;
  localparam int unsigned AC = 8;
  localparam int unsigned RC = 20;
  logic       clk;
  logic       rstn = 1'b0;
  logic       clr_n;
  logic       inh;
  logic       alert_n;
  logic       en_bus;
  logic       en_aux;
  logic       load;
  logic       cfg;
  logic [7:0] rdata;
  chg_req_s   req;
  chg_sense_s s;
  int         fails;
  int         tests_run;

  chg_safety_ctrl #(.ALERT_CYC(AC), .RETRY_CYC(RC), .NOPULSE_CYC(16),
    .WINDOW_CYC(16), .DETECT_CYC(8)) dut (
    .ref_clk_i(clk), .resetn_i(rstn), .req_i(req), .sense_i(s),
    .ceiling_clear_pin_n_i(clr_n), .charge_inhibit_pin_i(inh),
    .rdata_o(rdata), .alert_n_o(alert_n), .charge_en_bus_o(en_bus),
    .charge_en_aux_o(en_aux), .discharge_load_o(load), .config_mode_o(cfg));
  chg_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, e, m = 8'hff);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask : rdc
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr
  // Bounded wait on bus enable (0), alert (1), discharge (2) or aux (3).
  task automatic wt(input int k, input logic v, output int n);
    logic [3:0] w;
    tests_run++;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1 w = {en_aux, load, alert_n, en_bus};
      if (w[k] === v) return;
    end
    $display("unexpected wait %0d expected %b seen %b", k, v, w[k]);
    fails++;
    report_and_stop();
  endtask : wt
  task automatic nt(input logic v);
    @(posedge clk) begin
      s.vbat_near_target <= v;
      s.term_current     <= v;
    end
  endtask : nt
  task automatic reset_dut();
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
  endtask : reset_dut
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk("alert", 8'h01, alert_n);
    chk("config", 8'h01, cfg);
    rdc(8'h06, 8'h40);
    rdc(8'h05, 8'h03);
    rdc(8'h3f, 8'h00);
  endtask : t_regs
  task automatic t_ceil();
    @(posedge clk) s.vbat_above_short <= 1'b1;
    wr(8'h06, 8'hf5);
    rdc(8'h06, 8'ha5);
    wr(8'h02, 8'hfc);
    rdc(8'h02, 8'h5c);
    wr(8'h04, 8'h78);
    rdc(8'h04, 8'h50);
    wr(8'h06, 8'h11);
    rdc(8'h06, 8'ha5);
    @(posedge clk) clr_n <= 1'b0;
    rdc(8'h06, 8'h40);
    @(posedge clk) clr_n <= 1'b1;
  endtask : t_ceil
  task automatic t_chg();
    int n;
    @(posedge clk) s.input_recovered <= 1'b1;
    wt(0, 1'b1, n);
    chk("config", 8'h00, cfg);
    @(posedge clk) s.sag_loop <= 1'b1;
    rdc(8'h05, 8'h13);
    @(posedge clk) s.sag_loop <= 1'b0;
    rdc(8'h05, 8'h03);
    wr(8'h01, 8'h02);
    wt(0, 1'b0, n);
    wr(8'h01, 8'h00);
    wt(0, 1'b1, n);
    @(posedge clk) inh <= 1'b1;
    wt(0, 1'b0, n);
    @(posedge clk) inh <= 1'b0;
    wt(0, 1'b1, n);
    @(posedge clk) s.selected_input_rail <= 1'b1;
    wt(3, 1'b1, n);
    wr(8'h01, 8'h01);
    wt(3, 1'b0, n);
    wr(8'h01, 8'h00);
    @(posedge clk) s.selected_input_rail <= 1'b0;
    wt(0, 1'b1, n);
  endtask : t_chg
  task automatic t_faults();
    int n;
    int b;
    @(posedge clk) s.bus_ovp <= 1'b1;
    wt(1, 1'b0, n);
    wt(1, 1'b1, n);
    chk("alert width", 8'(AC - 1), n[7:0]);
    rdc(8'h00, 8'h31);
    rdc(8'h00, 8'h31);
    @(posedge clk) s.bus_ovp <= 1'b0;
    rdc(8'h00, 8'h01, 8'h07);
    rdc(8'h00, 8'h00, 8'h07);
    @(posedge clk) s.aux_ovp <= 1'b1;
    rdc(8'h07, 8'h31);
    @(posedge clk) s.aux_ovp <= 1'b0;
    rdc(8'h07, 8'h01, 8'h07);
    wt(0, 1'b1, n);
    @(posedge clk) s.die_hot <= 1'b1;
    rdc(8'h00, 8'h05, 8'h07);
    chk("bus enable", 8'h00, en_bus);
    @(posedge clk) s.die_hot <= 1'b0;
    wt(0, 1'b1, n);
    rdc(8'h00, 8'h05, 8'h07);
    @(posedge clk) s.input_low <= 1'b1;
    @(posedge clk) s.input_low <= 1'b0;
    wt(0, 1'b0, n);
    wt(0, 1'b1, b);
    chk("retry", 8'h01, 8'(n + b >= RC - 3));
    rdc(8'h00, 8'h03, 8'h07);
  endtask : t_faults
  task automatic t_detect();
    int n;
    nt(1'b1);
    wt(2, 1'b1, n);
    rdc(8'h00, 8'h20, 8'h30);
    wt(2, 1'b0, n);
    rdc(8'h00, 8'h00, 8'h07);
    nt(1'b0);
    wt(0, 1'b1, n);
    nt(1'b1);
    wt(2, 1'b1, n);
    nt(1'b0);
    wt(2, 1'b0, n);
    rdc(8'h00, 8'h07, 8'h07);
    rdc(8'h02, 8'h00);
    wt(0, 1'b1, n);
    wr(8'h01, 8'h08);
    @(posedge clk) {s.pwm_pulse, s.vbat_near_target} <= 2'b01;
    repeat (20) @(posedge clk);
    #1 chk("cutoff", 8'h01, en_bus);
    wr(8'h01, 8'h00);
    wt(0, 1'b0, n);
    chk("no pulse", 8'h01, 8'(n >= 12));
    rdc(8'h00, 8'h34);
    @(posedge clk) s.safety_timer_expired <= 1'b1;
    rdc(8'h00, 8'h06, 8'h07);
    @(posedge clk) s.safety_timer_expired <= 1'b0;
  endtask : t_detect
  task automatic t_window();
    reset_dut();
    @(posedge clk) begin
      s.unattended       <= 1'b1;
      s.selected_input_rail_por        <= 1'b1;
      s.vbat_above_short <= 1'b0;
    end
    @(posedge clk) begin
      s.selected_input_rail_por        <= 1'b0;
      s.vbat_above_short <= 1'b1;
    end
    @(posedge clk) s.vbat_above_3v7 <= 1'b1;
    rdc(8'h00, 8'h07, 8'h07);
    chk("config", 8'h01, cfg);
    chk("bus enable", 8'h00, en_bus);
  endtask : t_window
  ////////////////////////////////////////////////////////////
  initial begin
    clr_n = 1'b1;
    inh = 1'b0;
    s = '0;
    s.pwm_pulse = 1'b1;
    fails = 0;
    tests_run = 0;
    reset_dut();
    t_regs();
    t_ceil();
    t_chg();
    t_faults();
    t_detect();
    t_window();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire

// >>> design/chg_map.svh
`ifndef CHG_MAP_SVH
`define CHG_MAP_SVH

// Register offsets.
`define CHG_REG0       8'h00
`define CHG_REG1       8'h01
`define CHG_REG2       8'h02
`define CHG_REG4       8'h04
`define CHG_REG5       8'h05
`define CHG_REG6       8'h06
`define CHG_REG7       8'h07

// Field ranges.
`define CHG_FAULT_F    2:0
`define CHG_STATE_F    5:4
`define CHG_TE_B       3
`define CHG_BUSBLK_B   1
`define CHG_AUXBLK_B   0
`define CHG_VT_F       7:2
`define CHG_IT_F       6:3
`define CHG_SAGFLG_B   4
`define CHG_SAGSEL_F   2:0
`define CHG_ICEIL_F    7:4
`define CHG_VCEIL_F    3:0

// Reset values and limits.
`define CHG_REG1_RST   8'h00
`define CHG_VT_RST     6'h00
`define CHG_IT_RST     4'h0
`define CHG_SAGSEL_RST 3'h3
`define CHG_CEIL_RST   8'h40
`define CHG_ICEIL_MAX  4'ha
`define CHG_VCEIL_PAD  2'h3

// Fault codes.
`define CHG_F_NONE     3'h0
`define CHG_F_OVP      3'h1
`define CHG_F_UV       3'h3
`define CHG_F_BATOV    3'h4
`define CHG_F_THERM    3'h5
`define CHG_F_TIMER    3'h6
`define CHG_F_NOBAT    3'h7

// State codes.
`define CHG_S_READY    2'h0
`define CHG_S_CHARGE   2'h1
`define CHG_S_DONE     2'h2
`define CHG_S_FAULT    2'h3

// Timing, each time in its own unit.
`define CHG_CLK_NS     4
`define CHG_ALERT_US   125
`define CHG_RETRY_MS   2000
`define CHG_NOPULSE_MS 30
`define CHG_WINDOW_MS  32
`define CHG_DETECT_MS  10

// Timer slots.
`define CHG_T_ALERT    0
`define CHG_T_RETRY    1
`define CHG_T_NOPULSE  2
`define CHG_T_WINDOW   3
`define CHG_T_DETECT   4
`define CHG_T_NUM      5

`endif

// >>> design/chg_pkg.sv
package chg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chg_req_s;

  typedef struct packed {
    logic sag_loop;
    logic vbat_above_short;
    logic vbat_near_target;
    logic vbat_above_3v7;
    logic die_hot;
    logic input_low;
    logic input_recovered;
    logic bus_ovp;
    logic aux_ovp;
    logic pwm_pulse;
    logic term_current;
    logic unattended;
    logic selected_input_rail_por;
    logic safety_timer_expired;
    logic selected_input_rail;
  } chg_sense_s;

  typedef enum logic [2:0] {
    ST_CONFIG,
    ST_CHARGE,
    ST_UV_WAIT,
    ST_DETECT,
    ST_DONE
  } chg_state_e;

  typedef logic [2:0] chg_code_t;

endpackage : chg_pkg

// >>> design/chg_safety_ctrl.sv
// Overview of operation
// - Flag set while sag hold loop limits current.
// - Sag hold voltage programmable, three-bit default field.
// - Over-ceiling target writes store the ceiling value.
// - Ceiling loads default, locks after other writes.
// - Ceiling held at reset while clear pin low.
// - Current ceiling writes above ten store ten.
// - Thermal shutdown suspends, fault 101, timers other than the alert freeze.
// - Input below 3.7 V stops charge, fault 011.
// - Restart after recovery and two-second retry interval.
// - Bus over-voltage suspends bus, fault 001, resumes.
// - Aux over-voltage suspends aux, fault 001, state 11.
// - No pulses 30 ms without cutoff: fault 100.
// - Termination: state 10, discharge, battery present 000.
// - Battery absent: defaults, fault 111, retry delay.
// - Unattended power-up window detects missing battery.
// - Each new fault pulses alert low 125 us.
// - Fault code clears on read once condition clears.
// - Block bits stop charging from their input.
// - Inhibit pin high disables all charging.
// - Safety timer expiry reports fault code 110.
`include "chg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module chg_safety_ctrl #(
  parameter int unsigned ALERT_CYC =
    (`CHG_ALERT_US * 1000 + `CHG_CLK_NS - 1) / `CHG_CLK_NS,
  parameter int unsigned RETRY_CYC =
    (`CHG_RETRY_MS * 1000000 + `CHG_CLK_NS - 1) / `CHG_CLK_NS,
  parameter int unsigned NOPULSE_CYC =
    (`CHG_NOPULSE_MS * 1000000 + `CHG_CLK_NS - 1) / `CHG_CLK_NS,
  parameter int unsigned WINDOW_CYC =
    (`CHG_WINDOW_MS * 1000000) / `CHG_CLK_NS,
  parameter int unsigned DETECT_CYC =
    (`CHG_DETECT_MS * 1000000 + `CHG_CLK_NS - 1) / `CHG_CLK_NS
) (
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire chg_pkg::chg_req_s   req_i,
  input  wire chg_pkg::chg_sense_s sense_i,
  input  wire logic               ceiling_clear_pin_n_i,
  input  wire logic               charge_inhibit_pin_i,
  output var  logic [7:0]         rdata_o,
  output var  logic               alert_n_o,
  output var  logic               charge_en_bus_o,
  output var  logic               charge_en_aux_o,
  output var  logic               discharge_load_o,
  output var  logic               config_mode_o
);

  import chg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers and timers.

  chg_state_e st;
  chg_state_e next_st;
  chg_code_t  bus_input_error_code;
  chg_code_t  aux_input_error_code;
  chg_code_t  next_bus_err;
  chg_code_t  next_aux_err;
  logic [1:0] bus_input_state_code;
  logic [1:0] aux_input_state_code;
  logic [1:0] next_bus_st;
  logic [1:0] next_aux_st;
  logic [7:0] ctrl1;
  logic [5:0] battery_voltage_target;
  logic [3:0] charge_current_target;
  logic [2:0] sag_hold_sel;
  logic       input_sag_hold_flag;
  logic [7:0] charge_limit_ceiling;
  logic       ceiling_lock;
  logic       short_q;
  logic       hot_q;
  logic       bus_ovp_q;
  logic       aux_ovp_q;
  logic       stexp_q;
  logic       window_armed;
  logic       autochg_block;
  logic       retry_elapsed;
  logic       new_fault;

  logic [`CHG_T_NUM-1:0] t_start;
  logic [`CHG_T_NUM-1:0] t_run;
  logic [`CHG_T_NUM-1:0] t_busy;
  logic [`CHG_T_NUM-1:0] t_done;

  localparam int unsigned T_LOAD [`CHG_T_NUM] =
    '{ALERT_CYC, RETRY_CYC, NOPULSE_CYC, WINDOW_CYC, DETECT_CYC};

  for (genvar gi = 0; gi < `CHG_T_NUM; gi++) begin : g_tmr
    chg_timer u_tmr (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .start_i   (t_start[gi]),
      .run_i     (t_run[gi]),
      .load_i    (32'(T_LOAD[gi])),
      .busy_o    (t_busy[gi]),
      .done_o    (t_done[gi])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Events.

  logic sel_aux;
  logic hot;
  logic wr_any;
  logic short_rise;
  logic thermal_evt;
  logic uv_evt;
  logic bus_ovp_evt;
  logic aux_ovp_evt;
  logic nopulse_evt;
  logic stexp_evt;
  logic nobat_evt;
  logic det_end;
  logic bat_absent;
  logic bat_present;
  logic defaults_evt;
  logic finish_cutoff_on;
  logic bus_input_block;
  logic aux_input_block;

  assign sel_aux          = sense_i.selected_input_rail;
  assign hot              = sense_i.die_hot;
  assign wr_any           = req_i.wr;
  assign short_rise       = sense_i.vbat_above_short && !short_q;
  assign finish_cutoff_on = ctrl1[`CHG_TE_B];
  assign bus_input_block  = ctrl1[`CHG_BUSBLK_B];
  assign aux_input_block  = ctrl1[`CHG_AUXBLK_B];

  assign thermal_evt = hot && !hot_q;
  assign uv_evt      = (st == ST_CHARGE) && sense_i.input_low && !hot;
  assign bus_ovp_evt = sense_i.bus_ovp && !bus_ovp_q;
  assign aux_ovp_evt = sense_i.aux_ovp && !aux_ovp_q;
  assign nopulse_evt = t_done[`CHG_T_NOPULSE] && (st == ST_CHARGE)
                       && !finish_cutoff_on;
  assign stexp_evt   = sense_i.safety_timer_expired && !stexp_q;
  assign nobat_evt   = window_armed && t_busy[`CHG_T_WINDOW]
                       && sense_i.vbat_above_3v7;
  assign det_end     = (st == ST_DETECT) && t_done[`CHG_T_DETECT] && !hot;
  assign bat_present = det_end && sense_i.vbat_near_target;
  assign bat_absent  = det_end && !sense_i.vbat_near_target;
  assign defaults_evt = bat_absent || nobat_evt;

  // Only the alert keeps running in suspend, so the host still sees it.
  assign t_run = {{(`CHG_T_NUM-1){!hot}}, 1'b1};

  always_comb begin
    t_start = '0;
    t_start[`CHG_T_ALERT]   = new_fault;
    t_start[`CHG_T_RETRY]   = uv_evt || bat_absent;
    t_start[`CHG_T_NOPULSE] = sense_i.pwm_pulse || (st != ST_CHARGE)
                              || finish_cutoff_on;
    t_start[`CHG_T_WINDOW]  = window_armed && short_rise;
    t_start[`CHG_T_DETECT]  = (st == ST_CHARGE) && (next_st == ST_DETECT);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      short_q   <= 1'b0;
      hot_q     <= 1'b0;
      bus_ovp_q <= 1'b0;
      aux_ovp_q <= 1'b0;
      stexp_q   <= 1'b0;
    end else begin
      short_q   <= sense_i.vbat_above_short;
      hot_q     <= hot;
      bus_ovp_q <= sense_i.bus_ovp;
      aux_ovp_q <= sense_i.aux_ovp;
      stexp_q   <= sense_i.safety_timer_expired;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer. The state and all timers but the alert freeze while the die is hot.

  always_comb begin
    next_st = st;
    if (!hot) begin
      unique case (st)
        ST_CONFIG:
          if (sense_i.input_recovered && !autochg_block) begin
            next_st = ST_CHARGE;
          end
        ST_CHARGE:
          if (nobat_evt) begin
            next_st = ST_CONFIG;
          end else if (uv_evt) begin
            next_st = ST_UV_WAIT;
          end else if (nopulse_evt) begin
            next_st = ST_DONE;
          end else if (sense_i.vbat_near_target
                       && sense_i.term_current) begin
            next_st = ST_DETECT;
          end
        ST_UV_WAIT:
          if (retry_elapsed && sense_i.input_recovered) begin
            next_st = ST_CHARGE;
          end
        ST_DETECT:
          if (bat_present) begin
            next_st = ST_DONE;
          end else if (bat_absent) begin
            next_st = ST_UV_WAIT;
          end
        ST_DONE:
          if (!sense_i.vbat_near_target) begin
            next_st = ST_CHARGE;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st <= ST_CONFIG;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      retry_elapsed <= 1'b0;
    end else if (t_start[`CHG_T_RETRY]) begin
      retry_elapsed <= 1'b0;
    end else if (t_done[`CHG_T_RETRY]) begin
      retry_elapsed <= 1'b1;
    end
  end

  // A missing battery found at power-up blocks auto-charge until next POR.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      window_armed  <= 1'b0;
      autochg_block <= 1'b0;
    end else begin
      if (sense_i.selected_input_rail_por) begin
        window_armed  <= sense_i.unattended;
        autochg_block <= 1'b0;
      end else if (nobat_evt) begin
        window_armed  <= 1'b0;
        autochg_block <= 1'b1;
      end else if (t_done[`CHG_T_WINDOW]) begin
        window_armed  <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault and state codes. A new fault wins over a read clear.

  chg_code_t com_code;
  logic      com_evt;
  logic      bus_cond;
  logic      aux_cond;

  assign bus_cond = hot || sense_i.bus_ovp || (!sel_aux && uv_evt);
  assign aux_cond = hot || sense_i.aux_ovp || (sel_aux && uv_evt);

  always_comb begin
    com_evt  = 1'b1;
    com_code = `CHG_F_NONE;
    if (thermal_evt) begin
      com_code = `CHG_F_THERM;
    end else if (stexp_evt) begin
      com_code = `CHG_F_TIMER;
    end else if (uv_evt) begin
      com_code = `CHG_F_UV;
    end else if (nopulse_evt) begin
      com_code = `CHG_F_BATOV;
    end else if (bat_absent || nobat_evt) begin
      com_code = `CHG_F_NOBAT;
    end else begin
      com_evt  = 1'b0;
    end
  end

  always_comb begin
    next_bus_err = bus_input_error_code;
    next_aux_err = aux_input_error_code;
    next_bus_st  = bus_input_state_code;
    next_aux_st  = aux_input_state_code;
    new_fault    = 1'b0;
    if (req_i.rd && req_i.addr == `CHG_REG0 && !bus_cond) begin
      next_bus_err = `CHG_F_NONE;
    end
    if (req_i.rd && req_i.addr == `CHG_REG7 && !aux_cond) begin
      next_aux_err = `CHG_F_NONE;
    end
    if (t_start[`CHG_T_DETECT] || bat_present) begin
      if (sel_aux) begin
        next_aux_st = `CHG_S_DONE;
      end else begin
        next_bus_st = `CHG_S_DONE;
      end
    end
    if (bat_present) begin
      if (sel_aux) begin
        next_aux_err = `CHG_F_NONE;
      end else begin
        next_bus_err = `CHG_F_NONE;
      end
    end
    if (st != ST_CHARGE && next_st == ST_CHARGE) begin
      if (sel_aux) begin
        next_aux_st = `CHG_S_CHARGE;
      end else begin
        next_bus_st = `CHG_S_CHARGE;
      end
    end
    if (com_evt) begin
      new_fault = 1'b1;
      if (sel_aux) begin
        next_aux_err = com_code;
      end else begin
        next_bus_err = com_code;
      end
      if (uv_evt || nopulse_evt) begin
        if (sel_aux) begin
          next_aux_st = `CHG_S_FAULT;
        end else begin
          next_bus_st = `CHG_S_FAULT;
        end
      end
    end
    if (bus_ovp_evt) begin
      new_fault    = 1'b1;
      next_bus_err = `CHG_F_OVP;
      next_bus_st  = `CHG_S_FAULT;
    end
    if (aux_ovp_evt) begin
      new_fault    = 1'b1;
      next_aux_err = `CHG_F_OVP;
      next_aux_st  = `CHG_S_FAULT;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bus_input_error_code <= `CHG_F_NONE;
      aux_input_error_code <= `CHG_F_NONE;
      bus_input_state_code <= `CHG_S_READY;
      aux_input_state_code <= `CHG_S_READY;
    end else begin
      bus_input_error_code <= next_bus_err;
      aux_input_error_code <= next_aux_err;
      bus_input_state_code <= next_bus_st;
      aux_input_state_code <= next_aux_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Host registers.

  logic [5:0] vt_lim;
  logic [3:0] it_lim;
  logic [3:0] iceil_wr;

  assign vt_lim   = {charge_limit_ceiling[`CHG_VCEIL_F], `CHG_VCEIL_PAD};
  assign it_lim   = charge_limit_ceiling[`CHG_ICEIL_F];
  assign iceil_wr = (req_i.wdata[`CHG_ICEIL_F] > `CHG_ICEIL_MAX)
                    ? `CHG_ICEIL_MAX : req_i.wdata[`CHG_ICEIL_F];

  // Defaults are restored on battery loss; the ceiling keeps its own path.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || defaults_evt) begin
      ctrl1                  <= `CHG_REG1_RST;
      battery_voltage_target <= `CHG_VT_RST;
      charge_current_target  <= `CHG_IT_RST;
      sag_hold_sel           <= `CHG_SAGSEL_RST;
    end else if (wr_any) begin
      unique case (req_i.addr)
        `CHG_REG1: ctrl1 <= req_i.wdata;
        `CHG_REG2:
          battery_voltage_target <= (req_i.wdata[`CHG_VT_F] > vt_lim)
                                    ? vt_lim : req_i.wdata[`CHG_VT_F];
        `CHG_REG4:
          charge_current_target <= (req_i.wdata[`CHG_IT_F] > it_lim)
                                   ? it_lim : req_i.wdata[`CHG_IT_F];
        `CHG_REG5: sag_hold_sel <= req_i.wdata[`CHG_SAGSEL_F];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !ceiling_clear_pin_n_i) begin
      charge_limit_ceiling <= `CHG_CEIL_RST;
    end else if (short_rise || nobat_evt) begin
      charge_limit_ceiling <= `CHG_CEIL_RST;
    end else if (wr_any && req_i.addr == `CHG_REG6 && !ceiling_lock) begin
      charge_limit_ceiling <= {iceil_wr, req_i.wdata[`CHG_VCEIL_F]};
    end
  end

  // The lock outlives defaults_evt and the ceiling's own resets on purpose; only resetn_i or vbat_above_short low clears it.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !sense_i.vbat_above_short) begin
      ceiling_lock <= 1'b0;
    end else if (wr_any && req_i.addr != `CHG_REG6) begin
      ceiling_lock <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      input_sag_hold_flag <= 1'b0;
    end else begin
      input_sag_hold_flag <= sense_i.sag_loop && (st == ST_CHARGE);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      rdata_o <= 8'h00;
      unique case (req_i.addr)
        `CHG_REG0: begin
          rdata_o[`CHG_STATE_F] <= bus_input_state_code;
          rdata_o[`CHG_FAULT_F] <= bus_input_error_code;
        end
        `CHG_REG1: rdata_o <= ctrl1;
        `CHG_REG2: rdata_o[`CHG_VT_F] <= battery_voltage_target;
        `CHG_REG4: rdata_o[`CHG_IT_F] <= charge_current_target;
        `CHG_REG5: begin
          rdata_o[`CHG_SAGFLG_B] <= input_sag_hold_flag;
          rdata_o[`CHG_SAGSEL_F] <= sag_hold_sel;
        end
        `CHG_REG6: rdata_o <= charge_limit_ceiling;
        `CHG_REG7: begin
          rdata_o[`CHG_STATE_F] <= aux_input_state_code;
          rdata_o[`CHG_FAULT_F] <= aux_input_error_code;
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic charging;
  assign charging = (st == ST_CHARGE) && !hot && !charge_inhibit_pin_i;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      alert_n_o        <= 1'b1;
      charge_en_bus_o  <= 1'b0;
      charge_en_aux_o  <= 1'b0;
      discharge_load_o <= 1'b0;
      config_mode_o    <= 1'b1;
    end else begin
      alert_n_o        <= !t_busy[`CHG_T_ALERT];
      charge_en_bus_o  <= charging && !sel_aux && !bus_input_block
                          && !sense_i.bus_ovp;
      charge_en_aux_o  <= charging && sel_aux && !aux_input_block
                          && !sense_i.aux_ovp;
      discharge_load_o <= (st == ST_DETECT);
      config_mode_o    <= (st == ST_CONFIG);
    end
  end

endmodule : chg_safety_ctrl

`default_nettype wire

// >>> design/chg_timer.sv
`timescale 1ns/1ps
`default_nettype none

module chg_timer (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic        run_i,
  input  wire logic [31:0] load_i,
  output var  logic        busy_o,
  output var  logic        done_o
);

  logic [31:0] cnt;

  // A start while busy reloads, so the interval counts from the last start.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cnt    <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt    <= load_i;
        busy_o <= 1'b1;
      end else if (busy_o && run_i) begin
        if (cnt <= 32'h1) begin
          cnt    <= 32'h0;
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - 32'h1;
        end
      end
    end
  end

endmodule : chg_timer

`default_nettype wire
